/* ssprd_pkg.sv */
/*
  ssprd_pkg: shared types and constants for the response and read data service.
  Assumes one 250 MHz clock and a synchronous active-high reset in every user but ssprd_sense_mem.
*/
package ssprd_pkg;

  localparam int unsigned SNS_MAX_BYTES = 32;
  localparam int unsigned SNS_AW = 5;
  localparam logic [7:0] STS_INTERMEDIATE = 8'h10;
  localparam logic [7:0] STS_INTERMEDIATE_CM = 8'h14;
  localparam logic [7:0] RSP_CODE_INVALID_FRAME = 8'h02;
  localparam logic [7:0] RSP_CODE_OVERLAPPED_TAG = 8'h0A;
  localparam logic [1:0] DP_NO_DATA = 2'h0;
  localparam logic [1:0] DP_RESPONSE_DATA = 2'h1;
  localparam logic [1:0] DP_SENSE_DATA = 2'h2;
  localparam logic [31:0] SNS_LEN_RST = 32'h0000_0000;
  localparam logic [7:0] STS_RST = 8'h00;

  typedef enum logic [1:0]
  {
    SSPRD_SR_NONE = 2'h0,
    SSPRD_SR_TASK_COMPLETE = 2'h1,
    SSPRD_SR_LINKED_COMPLETE = 2'h2,
    SSPRD_SR_DELIVERY_FAILURE = 2'h3
  } ssprd_svc_rsp_t;

  typedef struct packed
  {
    logic [63:0] lun;
    logic [15:0] tag;
  } ssprd_lq_t;

  typedef struct packed
  {
    logic [63:0] init_addr;
    logic [63:0] tgt_addr;
    ssprd_lq_t lq;
  } ssprd_nexus_t;

  typedef struct packed
  {
    ssprd_lq_t lq;
    logic [1:0] datapres;
    logic [7:0] status;
    logic [7:0] rsp_code;
    logic [31:0] sns_len_field;
    logic len_bad;
  } ssprd_rsp_hdr_t;

  typedef struct packed
  {
    ssprd_nexus_t nexus;
    logic [31:0] data_offset;
    logic [23:0] byte_count;
  } ssprd_rd_req_t;

  typedef enum logic [1:0]
  {
    SSPRD_TX_IDLE = 2'b00,
    SSPRD_TX_HDR = 2'b01,
    SSPRD_TX_PAY = 2'b11
  } ssprd_tx_st_t;

endpackage

/* ssprd_sense_mem.sv */
/*
  ssprd_sense_mem: small sense byte store, one write port, registered read.
  Assumes writes and reads on the same clock.
*/
module ssprd_sense_mem (
  input wire logic core_clk_i,
  input wire logic wr_en_i,
  input wire logic [ssprd_pkg::SNS_AW-1:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [ssprd_pkg::SNS_AW-1:0] rd_addr_i,
  output logic [7:0] rd_data_o
);

  logic [7:0] mem [ssprd_pkg::SNS_MAX_BYTES];

  always_ff @(posedge core_clk_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

endmodule // ssprd_sense_mem

/* ssprd_core.sv */
/*
  ssprd_core: initiator completion reporting and target read DATA framing.
  Assumes parsed response fields arrive from the link receiver on this clock,
  and the device server keeps its own ordering of read requests.
*/
// Overview of operation
// RULE_01: report received sense bytes on completion
// RULE_02: sense length is min(field, bytes received)
// RULE_03: report STATUS field as command status
// RULE_04: no/sense data, non-intermediate: task complete
// RULE_05: no/sense data, intermediate: linked command complete
// RULE_06: bad code, NAK or bad length: failure
// RULE_07: read requests only during read commands; the core takes any valid request while idle, with no command check
// RULE_08: no reads after completion or abort; the core does not gate read requests on completions or aborts
// RULE_09: frame goes to nexus initiator from target
// RULE_10: header carries request LUN and tag
// RULE_11: DATA OFFSET from client buffer offset
// RULE_12: payload sized by request byte count
// RULE_13: report LUN and tag from response or command
module ssprd_core (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sns_valid_i,
  input wire logic [7:0] sns_byte_i,
  input wire logic rsp_valid_i,
  input wire ssprd_pkg::ssprd_rsp_hdr_t rsp_hdr_i,
  input wire logic cmd_nak_i,
  input wire ssprd_pkg::ssprd_lq_t cmd_lq_i,
  input wire logic [ssprd_pkg::SNS_AW-1:0] sns_rd_addr_i,
  output logic cpl_valid_o,
  output ssprd_pkg::ssprd_lq_t cpl_lq_o,
  output logic [7:0] cpl_status_o,
  output logic [31:0] cpl_sns_len_o,
  output ssprd_pkg::ssprd_svc_rsp_t cpl_svc_rsp_o,
  output logic [7:0] cpl_sns_byte_o,
  input wire logic rd_req_valid_i,
  input wire ssprd_pkg::ssprd_rd_req_t rd_req_i,
  output logic rd_req_ready_o,
  input wire logic pay_valid_i,
  input wire logic [7:0] pay_byte_i,
  output logic pay_ready_o,
  input wire logic tx_ready_i,
  output logic tx_hdr_valid_o,
  output ssprd_pkg::ssprd_rd_req_t tx_hdr_o,
  output logic tx_byte_valid_o,
  output logic [7:0] tx_byte_o,
  output logic tx_last_o
);

  // ---------------- initiator side: completion report ----------------
  logic [31:0] sns_cnt_q;
  logic [31:0] sns_cnt_d;
  logic sns_wr_en;
  logic [ssprd_pkg::SNS_AW-1:0] sns_wr_addr;
  logic status_intermediate;
  logic datapres_ok;
  logic code_fail;
  logic [31:0] sns_len_min;
  ssprd_pkg::ssprd_svc_rsp_t svc_rsp;

  function automatic logic is_intermediate(input logic [7:0] st);
    return (st == ssprd_pkg::STS_INTERMEDIATE) || (st == ssprd_pkg::STS_INTERMEDIATE_CM);
  endfunction

  // RULE_01 store sense bytes
  assign sns_wr_en = sns_valid_i && (sns_cnt_q < ssprd_pkg::SNS_MAX_BYTES);
  assign sns_wr_addr = sns_cnt_q[ssprd_pkg::SNS_AW-1:0];
  assign sns_cnt_d = rsp_valid_i ? 32'h0000_0000 : (sns_valid_i ? sns_cnt_q + 32'h1 : sns_cnt_q);

  ssprd_sense_mem i_ssprd_sense_mem (
    .core_clk_i(core_clk_i),
    .wr_en_i(sns_wr_en),
    .wr_addr_i(sns_wr_addr),
    .wr_data_i(sns_byte_i),
    .rd_addr_i(sns_rd_addr_i),
    .rd_data_o(cpl_sns_byte_o)
  );

  // RULE_02 minimum of field and count
  assign sns_len_min = (rsp_hdr_i.sns_len_field < sns_cnt_q) ? rsp_hdr_i.sns_len_field : sns_cnt_q;

  assign status_intermediate = is_intermediate(rsp_hdr_i.status);
  assign datapres_ok = (rsp_hdr_i.datapres == ssprd_pkg::DP_NO_DATA)
                    || (rsp_hdr_i.datapres == ssprd_pkg::DP_SENSE_DATA);
  assign code_fail = (rsp_hdr_i.datapres == ssprd_pkg::DP_RESPONSE_DATA)
                  && ((rsp_hdr_i.rsp_code == ssprd_pkg::RSP_CODE_INVALID_FRAME)
                   || (rsp_hdr_i.rsp_code == ssprd_pkg::RSP_CODE_OVERLAPPED_TAG));

  // RULE_06 failure wins over other classes
  // RULE_04 task complete
  // RULE_05 linked command complete
  assign svc_rsp = (cmd_nak_i || rsp_hdr_i.len_bad || code_fail)
                   ? ssprd_pkg::SSPRD_SR_DELIVERY_FAILURE
                 : (datapres_ok && !status_intermediate) ? ssprd_pkg::SSPRD_SR_TASK_COMPLETE
                 : datapres_ok ? ssprd_pkg::SSPRD_SR_LINKED_COMPLETE
                 : ssprd_pkg::SSPRD_SR_NONE;

  // sense byte counter, cleared by each parsed response
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      sns_cnt_q <= 32'h0000_0000;
    end
    else
    begin
      sns_cnt_q <= sns_cnt_d;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cpl_valid_o <= 1'b0;
    end
    else
    begin
      cpl_valid_o <= rsp_valid_i || cmd_nak_i;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cpl_lq_o <= '0;
    end
    else if (cmd_nak_i)
    begin
      // RULE_13 no response frame: command header
      cpl_lq_o <= cmd_lq_i;
    end
    else if (rsp_valid_i)
    begin
      // RULE_13 response header identity
      cpl_lq_o <= rsp_hdr_i.lq;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cpl_status_o <= ssprd_pkg::STS_RST;
    end
    else if (cmd_nak_i)
    begin
      cpl_status_o <= ssprd_pkg::STS_RST;
    end
    else if (rsp_valid_i)
    begin
      // RULE_03 status passthrough
      cpl_status_o <= rsp_hdr_i.status;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cpl_sns_len_o <= ssprd_pkg::SNS_LEN_RST;
    end
    else if (cmd_nak_i)
    begin
      cpl_sns_len_o <= 32'h0000_0000;
    end
    else if (rsp_valid_i)
    begin
      // RULE_02 reported length
      cpl_sns_len_o <= sns_len_min;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cpl_svc_rsp_o <= ssprd_pkg::SSPRD_SR_NONE;
    end
    else if (cmd_nak_i)
    begin
      // RULE_06 nak means delivery failure
      cpl_svc_rsp_o <= ssprd_pkg::SSPRD_SR_DELIVERY_FAILURE;
    end
    else if (rsp_valid_i)
    begin
      cpl_svc_rsp_o <= svc_rsp;
    end
  end

  // ---------------- target side: read DATA frame ----------------
  ssprd_pkg::ssprd_tx_st_t st_q;
  ssprd_pkg::ssprd_tx_st_t st_d;
  logic [23:0] left_q;
  logic [23:0] left_d;
  logic take_req;
  logic hdr_sent;
  logic byte_sent;
  logic pay_take;

  assign take_req = (st_q == ssprd_pkg::SSPRD_TX_IDLE) && rd_req_valid_i;
  assign hdr_sent = (st_q == ssprd_pkg::SSPRD_TX_HDR) && tx_hdr_valid_o && tx_ready_i;
  assign byte_sent = (st_q == ssprd_pkg::SSPRD_TX_PAY) && tx_byte_valid_o && tx_ready_i;
  assign pay_take = pay_ready_o && pay_valid_i;
  // RULE_12 payload length counts down
  assign left_d = take_req ? rd_req_i.byte_count
                : pay_take ? left_q - 24'h1 : left_q;

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ssprd_pkg::SSPRD_TX_IDLE:
      begin
        if (take_req)
        begin
          st_d = ssprd_pkg::SSPRD_TX_HDR;
        end
      end
      ssprd_pkg::SSPRD_TX_HDR:
      begin
        if (hdr_sent)
        begin
          st_d = (left_q == 24'h00_0000) ? ssprd_pkg::SSPRD_TX_IDLE : ssprd_pkg::SSPRD_TX_PAY;
        end
      end
      ssprd_pkg::SSPRD_TX_PAY:
      begin
        if (byte_sent && tx_last_o)
        begin
          st_d = ssprd_pkg::SSPRD_TX_IDLE;
        end
      end
      default:
      begin
        st_d = ssprd_pkg::SSPRD_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      st_q <= ssprd_pkg::SSPRD_TX_IDLE;
      left_q <= 24'h00_0000;
    end
    else
    begin
      st_q <= st_d;
      left_q <= left_d;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      rd_req_ready_o <= 1'b0;
    end
    else
    begin
      rd_req_ready_o <= (st_d == ssprd_pkg::SSPRD_TX_IDLE) && !take_req;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      tx_hdr_valid_o <= 1'b0;
      tx_hdr_o <= '0;
    end
    else if (take_req)
    begin
      // RULE_09 addressed by request nexus
      // RULE_10 LUN and tag copied
      // RULE_11 data offset copied
      tx_hdr_o <= rd_req_i;
      tx_hdr_valid_o <= 1'b1;
    end
    else if (hdr_sent)
    begin
      tx_hdr_valid_o <= 1'b0;
    end
  end

  // one payload byte in flight at a time
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      tx_byte_valid_o <= 1'b0;
      tx_byte_o <= 8'h00;
      tx_last_o <= 1'b0;
    end
    else if (pay_take)
    begin
      tx_byte_o <= pay_byte_i;
      tx_byte_valid_o <= 1'b1;
      tx_last_o <= (left_q == 24'h00_0001);
    end
    else if (byte_sent)
    begin
      tx_byte_valid_o <= 1'b0;
      tx_last_o <= 1'b0;
    end
  end

  // zero-length request leaves this low: header only
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pay_ready_o <= 1'b0;
    end
    else
    begin
      pay_ready_o <= (st_d == ssprd_pkg::SSPRD_TX_PAY) && (left_d != 24'h00_0000)
                  && !pay_take && !(tx_byte_valid_o && !byte_sent);
    end
  end

endmodule // ssprd_core

/* ssprd_core_sva.sv */
/*
  ssprd_core_sva: port checker for ssprd_core.
  Assumes it is bound to ssprd_core and sees only its ports.
*/
module ssprd_chk (
  input wire logic core_clk_i,
  input wire logic pay_ready_o,
  input wire logic rst_i,
  input wire logic rsp_valid_i,
  input wire ssprd_pkg::ssprd_rsp_hdr_t rsp_hdr_i,
  input wire logic cmd_nak_i,
  input wire ssprd_pkg::ssprd_lq_t cmd_lq_i,
  input wire logic cpl_valid_o,
  input wire ssprd_pkg::ssprd_lq_t cpl_lq_o,
  input wire logic [7:0] cpl_status_o,
  input wire ssprd_pkg::ssprd_svc_rsp_t cpl_svc_rsp_o,
  input wire logic rd_req_valid_i,
  input wire ssprd_pkg::ssprd_rd_req_t rd_req_i,
  input wire logic rd_req_ready_o,
  input wire logic tx_ready_i,
  input wire logic tx_hdr_valid_o,
  input wire ssprd_pkg::ssprd_rd_req_t tx_hdr_o,
  input wire logic tx_byte_valid_o,
  input wire logic [7:0] tx_byte_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rsp; rsp_valid_i && !cmd_nak_i; endsequence
  sequence s_take; rd_req_valid_i && rd_req_ready_o; endsequence
  sequence s_hdr_wait; tx_hdr_valid_o && !tx_ready_i; endsequence
  a_cpl_follows: assert property ((rsp_valid_i || cmd_nak_i) |=> cpl_valid_o)
    else $error("completion report missing");
  a_cpl_cause: assert property (cpl_valid_o |-> $past(rsp_valid_i || cmd_nak_i))
    else $error("completion report without cause");
  a_status_copy: assert property (s_rsp |=> cpl_status_o == $past(rsp_hdr_i.status))
    else $error("status not copied");
  a_lq_rsp: assert property (s_rsp |=> cpl_lq_o == $past(rsp_hdr_i.lq))
    else $error("lun or tag not from response");
  a_nak_fail: assert property (cmd_nak_i |=> cpl_lq_o == $past(cmd_lq_i)
    && cpl_svc_rsp_o == ssprd_pkg::SSPRD_SR_DELIVERY_FAILURE)
    else $error("nak not reported as failure");
  a_len_bad: assert property (rsp_valid_i && rsp_hdr_i.len_bad
    |=> cpl_svc_rsp_o == ssprd_pkg::SSPRD_SR_DELIVERY_FAILURE)
    else $error("bad length not reported as failure");
  a_hdr_take: assert property (s_take |=> tx_hdr_valid_o && tx_hdr_o == $past(rd_req_i))
    else $error("header not copied from request");
  a_hdr_hold: assert property (s_hdr_wait |=> tx_hdr_valid_o && $stable(tx_hdr_o))
    else $error("header dropped before accept");
  a_byte_hold: assert property (tx_byte_valid_o && !tx_ready_i
    |=> tx_byte_valid_o && $stable(tx_byte_o))
    else $error("byte dropped before accept");
  a_one_byte: assert property (pay_ready_o |-> !tx_byte_valid_o)
    else $error("payload asked while a byte is pending");
endmodule // ssprd_chk

bind ssprd_core ssprd_chk i_ssprd_chk (.*);

/* ssprd_link_model.sv */
/*
  ssprd_link_model: link sink and payload source beside ssprd_core.
  Assumes the core clock; the bench picks prompt or stalling mode.
*/
module ssprd_link_model (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic pay_ready_i,
  output logic pay_valid_o,
  output logic [7:0] pay_byte_o,
  output logic tx_ready_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_q;
  logic tgl_q;
  // bytes follow a running count; an idle bus shows the inverse
  assign pay_valid_o = pay_ready_i;
  assign pay_byte_o = pay_ready_i ? cnt_q : ~cnt_q;
  assign tx_ready_o = !slow_i || tgl_q;
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 8'h00;
      tgl_q <= 1'b0;
    end
    else
    begin
      tgl_q <= !tgl_q;
      cnt_q <= cnt_q + {7'h00, pay_ready_i};
    end
  end
endmodule // ssprd_link_model

/* tb_ssp_response_and_read_data_service.sv */
/*
  tb_ssp_response_and_read_data_service: self-checking bench for ssprd_core.
  Assumes ssprd_link_model stands at the link and payload side.
*/
module tb_ssp_response_and_read_data_service;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sns_valid_i = 1'b0;
  logic [7:0] sns_byte_i = 8'h00;
  logic rsp_valid_i = 1'b0;
  ssprd_pkg::ssprd_rsp_hdr_t rsp_hdr_i = '0;
  logic cmd_nak_i = 1'b0;
  ssprd_pkg::ssprd_lq_t cmd_lq_i = {64'h0000_0000_0000_0099, 16'h0F0F};
  logic [4:0] sns_rd_addr_i = 5'h00;
  logic rd_req_valid_i = 1'b0;
  ssprd_pkg::ssprd_rd_req_t rd_req_i = '0;
  logic slow = 1'b0;
  logic cpl_valid_o, rd_req_ready_o, pay_valid_i, pay_ready_o, tx_ready_i;
  logic tx_hdr_valid_o, tx_byte_valid_o, tx_last_o;
  logic [7:0] cpl_status_o, cpl_sns_byte_o, pay_byte_i, tx_byte_o;
  logic [7:0] exp_b = 8'h00;
  logic [31:0] cpl_sns_len_o;
  ssprd_pkg::ssprd_lq_t cpl_lq_o;
  ssprd_pkg::ssprd_svc_rsp_t cpl_svc_rsp_o;
  ssprd_pkg::ssprd_rd_req_t tx_hdr_o;
  int mismatches = 0;
  int comparisons = 0;

  ssprd_core i_ssprd_core (.*);
  ssprd_link_model i_ssprd_link_model (.core_clk_i, .rst_i, .slow_i(slow),
    .pay_ready_i(pay_ready_o), .pay_valid_o(pay_valid_i), .pay_byte_o(pay_byte_i),
    .tx_ready_o(tx_ready_i));

  task automatic chk(string what, logic [263:0] e, logic [263:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic run_cpl(logic nak, logic [1:0] dp, logic [7:0] st, logic [7:0] rc,
    logic bad, int n, logic [31:0] fld, ssprd_pkg::ssprd_svc_rsp_t es);
    ssprd_pkg::ssprd_rsp_hdr_t h;
    h = {64'h1122_3344_5566_7788, 16'hA500 + n[15:0], dp, st, rc, fld, bad};
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk_i);
      sns_valid_i <= 1'b1;
      sns_byte_i <= 8'hB0 + 8'(i);
    end
    @(posedge core_clk_i);
    sns_valid_i <= 1'b0;
    rsp_valid_i <= !nak;
    cmd_nak_i <= nak;
    rsp_hdr_i <= h;
    @(posedge core_clk_i);
    rsp_valid_i <= 1'b0;
    cmd_nak_i <= 1'b0;
    #1;
    chk("cpl_valid", 1, cpl_valid_o);
    chk("cpl_svc", es, cpl_svc_rsp_o);
    chk("cpl_lq", nak ? cmd_lq_i : h.lq, cpl_lq_o);
    if (!nak)
    begin
      chk("cpl_status", st, cpl_status_o);
      chk("cpl_sns_len", (fld < n) ? fld : n, cpl_sns_len_o);
    end
    @(posedge core_clk_i);
    #1;
    if (n > 0)
      chk("cpl_sns_byte", 8'hB0, cpl_sns_byte_o);
    @(posedge core_clk_i);
    sns_rd_addr_i <= (n > 32) ? 5'h1F : 5'(n - 1);
    @(posedge core_clk_i);
    #1;
    if (n > 0)
      chk("cpl_sns_last", (n > 32) ? 8'hCF : 8'hB0 + 8'(n - 1), cpl_sns_byte_o);
    @(posedge core_clk_i);
    sns_rd_addr_i <= 5'h00;
    $display("completion case done");
  endtask

  task automatic run_rd(logic [23:0] cnt, logic s);
    ssprd_pkg::ssprd_rd_req_t r;
    int k;
    int n;
    r = {64'h5000_0000_0000_0001, 64'h5000_0000_0000_0002, 64'h7, 16'h1200 + 16'(cnt),
      32'h0000_1000 + 32'(cnt), cnt};
    k = 0;
    n = 0;
    @(posedge core_clk_i);
    slow <= s;
    rd_req_valid_i <= 1'b1;
    rd_req_i <= r;
    do @(posedge core_clk_i); while (!rd_req_ready_o && ++k < 50);
    chk("rd_req_ready", 1, rd_req_ready_o);
    rd_req_valid_i <= 1'b0;
    do @(posedge core_clk_i); while (!(tx_hdr_valid_o && tx_ready_i) && ++k < 100);
    chk("tx_hdr_valid", 1, tx_hdr_valid_o && tx_ready_i);
    chk("tx_hdr", r, tx_hdr_o);
    for (int j = 0; j < 400 && n < cnt; j++)
    begin
      @(posedge core_clk_i);
      if (tx_byte_valid_o && tx_ready_i)
      begin
        chk("tx_byte", exp_b, tx_byte_o);
        chk("tx_last", n == cnt - 1, tx_last_o);
        exp_b++;
        n++;
      end
    end
    chk("tx_count", cnt, n);
    $display("read frame done");
  endtask

  initial
  begin
    forever #2 core_clk_i = !core_clk_i;
  end

  initial
  begin
    #20000;
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    run_cpl(0, ssprd_pkg::DP_NO_DATA, 8'h02, 0, 0, 0, 0, ssprd_pkg::SSPRD_SR_TASK_COMPLETE);
    run_cpl(0, ssprd_pkg::DP_SENSE_DATA, ssprd_pkg::STS_INTERMEDIATE, 0, 0, 5, 3,
      ssprd_pkg::SSPRD_SR_LINKED_COMPLETE);
    run_cpl(0, ssprd_pkg::DP_SENSE_DATA, ssprd_pkg::STS_INTERMEDIATE_CM, 0, 0, 34, 40,
      ssprd_pkg::SSPRD_SR_LINKED_COMPLETE);
    run_cpl(0, ssprd_pkg::DP_RESPONSE_DATA, 0, ssprd_pkg::RSP_CODE_INVALID_FRAME, 0, 0, 0,
      ssprd_pkg::SSPRD_SR_DELIVERY_FAILURE);
    run_cpl(0, ssprd_pkg::DP_RESPONSE_DATA, 0, ssprd_pkg::RSP_CODE_OVERLAPPED_TAG, 0, 0, 0,
      ssprd_pkg::SSPRD_SR_DELIVERY_FAILURE);
    run_cpl(0, ssprd_pkg::DP_NO_DATA, 0, 0, 1, 0, 0, ssprd_pkg::SSPRD_SR_DELIVERY_FAILURE);
    run_cpl(1, 0, 0, 0, 0, 0, 0, ssprd_pkg::SSPRD_SR_DELIVERY_FAILURE);
    run_rd(24'h000001, 1'b0);
    run_rd(24'h000005, 1'b1);
    run_rd(24'h000003, 1'b0);
    run_rd(24'h000000, 1'b1);
    report_and_stop();
  end
endmodule // tb_ssp_response_and_read_data_service
